// File: design/hst_pkg.sv
// Constants for the hardware-source trace packetizer
package hst_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_FUNC   = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_CYCLE  = 8'h0C;
	// Control fields
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_TAP_BIT   = 1;
	localparam int CTRL_RLD_LO    = 4;
	localparam int CTRL_RLD_HI    = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] CTRL_MASK  = 8'hF3;
	// Comparator function fields, four bits per comparator
	localparam int FUNC_CAP_BIT = 0;
	localparam int FUNC_PC_BIT  = 1;
	localparam int FUNC_OFS_BIT = 2;
	localparam logic [15:0] FUNC_RESET = 16'h0000;
	localparam logic [15:0] FUNC_MASK  = 16'h7777;
	// Cycle counter taps
	localparam int TAP_LO = 6;
	localparam int TAP_HI = 10;
	// Header pieces
	localparam logic [4:0] DISC_EXC = 5'h01;
	localparam logic [4:0] DISC_SMP = 5'h02;
	localparam logic [1:0] TYPE_PC  = 2'h1;
	localparam logic [1:0] TYPE_VAL = 2'h2;
	localparam logic       HW_SRC   = 1'b1;
	localparam logic [1:0] SS_1B = 2'h1;
	localparam logic [1:0] SS_2B = 2'h2;
	localparam logic [1:0] SS_4B = 2'h3;
	// Exception actions
	localparam logic [1:0] ACT_NONE = 2'h0;
	// Transfer sizes
	localparam logic [1:0] XS_BYTE = 2'h0;
	localparam logic [1:0] XS_HALF = 2'h1;
	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {ST_IDLE, ST_DT_VALUE} hst_state_e;
endpackage

// File: design/hst_packetizer.sv
// Hardware-source trace packet builder with AXI4-Lite control
`timescale 1ns/1ps
module hst_packetizer #(
	parameter int RLD_W = 4
) (
	input  wire logic        CORE_CLK,
	input  wire logic        NRST,
	input  wire logic [7:0]  AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	input  wire logic [7:0]  ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	input  wire logic        EXC_VALID,
	output logic             EXC_READY,
	input  wire logic [1:0]  EXC_ACTION,
	input  wire logic [8:0]  EXC_INDEX,
	input  wire logic [31:0] CORE_PC,
	input  wire logic        CORE_SLEEPING,
	input  wire logic        DT_VALID,
	output logic             DT_READY,
	input  wire logic [1:0]  DT_CMP,
	input  wire logic [31:0] DT_PC,
	input  wire logic [15:0] DT_OFFSET,
	input  wire logic [31:0] DT_DATA,
	input  wire logic [1:0]  DT_SIZE,
	input  wire logic        DT_WRITE,
	output logic             PKT_VALID,
	input  wire logic        PKT_READY,
	output logic [7:0]       PKT_HEADER,
	output logic [31:0]      PKT_PAYLOAD
);
	if (RLD_W != hst_pkg::CTRL_RLD_HI - hst_pkg::CTRL_RLD_LO + 1) begin : g_bad_rld
		$error("RLD_W must match the reload field");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] hdr(input logic [4:0] disc, input logic [1:0] ss);
		hdr = {disc, hst_pkg::HW_SRC, ss};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
		for (int i = 0; i < 4; i++)
			merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [7:0]              ctrl_q;
	logic [15:0]             func_q;
	logic [31:0]             cyc_q;
	logic [RLD_W-1:0]        interval_q;
	logic                    tap_prev_q;
	logic                    samp_pend_q;
	logic                    samp_sleep_q;
	logic [31:0]             samp_pc_q;
	hst_pkg::hst_state_e     st_q;
	logic [1:0]              dv_cmp_q;
	logic [1:0]              dv_size_q;
	logic                    dv_wr_q;
	logic [31:0]             dv_data_q;
	logic                    pkt_valid_q;
	logic [7:0]              pkt_hdr_q;
	logic [31:0]             pkt_pay_q;
	logic                    aw_full_q, w_full_q, bvalid_q, rvalid_q;
	logic [7:0]              awaddr_q;
	logic [31:0]             wdata_q, rdata_q;
	logic [3:0]              wstrb_q;
	logic [1:0]              bresp_q, rresp_q;

	// ----------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------
	logic wr_do;
	assign AWREADY = !aw_full_q;
	assign WREADY  = !w_full_q;
	assign ARREADY = !rvalid_q;
	assign BVALID  = bvalid_q;
	assign BRESP   = bresp_q;
	assign RVALID  = rvalid_q;
	assign RDATA   = rdata_q;
	assign RRESP   = rresp_q;
	assign wr_do   = aw_full_q && w_full_q && !bvalid_q;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (AWVALID && !aw_full_q) begin
				aw_full_q <= 1'b1;
				awaddr_q  <= AWADDR;
			end else if (wr_do) begin
				aw_full_q <= 1'b0;
			end
			if (WVALID && !w_full_q) begin
				w_full_q <= 1'b1;
				wdata_q  <= WDATA;
				wstrb_q  <= WSTRB;
			end else if (wr_do) begin
				w_full_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			bvalid_q <= 1'b0;
			bresp_q  <= hst_pkg::RESP_OKAY;
		end else if (wr_do) begin
			bvalid_q <= 1'b1;
			bresp_q  <= (awaddr_q == hst_pkg::ADDR_CTRL || awaddr_q == hst_pkg::ADDR_FUNC)
				? hst_pkg::RESP_OKAY : hst_pkg::RESP_SLVERR;
		end else if (BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			ctrl_q <= hst_pkg::CTRL_RESET;
			func_q <= hst_pkg::FUNC_RESET;
		end else if (wr_do) begin
			if (awaddr_q == hst_pkg::ADDR_CTRL)
				ctrl_q <= 8'(merge({24'h00_0000, ctrl_q}, wdata_q, wstrb_q)) & hst_pkg::CTRL_MASK;
			if (awaddr_q == hst_pkg::ADDR_FUNC)
				func_q <= 16'(merge({16'h0000, func_q}, wdata_q, wstrb_q)) & hst_pkg::FUNC_MASK;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= hst_pkg::RESP_OKAY;
		end else if (ARVALID && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rresp_q  <= hst_pkg::RESP_OKAY;
			case (ARADDR)
				hst_pkg::ADDR_CTRL:   rdata_q <= {24'h00_0000, ctrl_q};
				hst_pkg::ADDR_FUNC:   rdata_q <= {16'h0000, func_q};
				hst_pkg::ADDR_STATUS: rdata_q <= {20'h0_0000, interval_q, 5'h00, st_q, samp_pend_q, pkt_valid_q};
				hst_pkg::ADDR_CYCLE:  rdata_q <= cyc_q;
				default: begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= hst_pkg::RESP_SLVERR;
				end
			endcase
		end else if (RREADY) begin
			rvalid_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Sample interval timer
	// ----------------------------------------
	logic pc_en, tap_bit, tick, expire;
	assign pc_en   = ctrl_q[hst_pkg::CTRL_EN_BIT];
	assign tap_bit = ctrl_q[hst_pkg::CTRL_TAP_BIT] ? cyc_q[hst_pkg::TAP_HI] : cyc_q[hst_pkg::TAP_LO];
	assign tick    = tap_bit && !tap_prev_q;
	assign expire  = pc_en && tick && interval_q == '0;

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			cyc_q      <= 32'h0000_0000;
			tap_prev_q <= 1'b0;
			interval_q <= '0;
		end else begin
			cyc_q      <= cyc_q + 32'h0000_0001;
			tap_prev_q <= tap_bit;
			if (!pc_en)
				interval_q <= ctrl_q[hst_pkg::CTRL_RLD_HI:hst_pkg::CTRL_RLD_LO];
			else if (tick)
				interval_q <= (interval_q == '0) ? ctrl_q[hst_pkg::CTRL_RLD_HI:hst_pkg::CTRL_RLD_LO]
					: interval_q - 1'b1;
		end
	end

	// ----------------------------------------
	// Output selection
	// ----------------------------------------
	logic        load_ok, load, dt_take, exc_take, smp_take, go_second;
	logic [7:0]  nxt_hdr;
	logic [31:0] nxt_pay;
	logic [3:0]  func_sel;
	logic [1:0]  dt_ss;

	assign load_ok = !pkt_valid_q || PKT_READY;
	assign func_sel = func_q[DT_CMP*4 +: 4];
	assign dt_ss   = (DT_SIZE == hst_pkg::XS_BYTE) ? hst_pkg::SS_1B
		: (DT_SIZE == hst_pkg::XS_HALF) ? hst_pkg::SS_2B : hst_pkg::SS_4B;

	always_comb begin
		load      = 1'b0;
		dt_take   = 1'b0;
		exc_take  = 1'b0;
		smp_take  = 1'b0;
		go_second = 1'b0;
		nxt_hdr   = 8'h00;
		nxt_pay   = 32'h0000_0000;
		EXC_READY = 1'b0;
		DT_READY  = 1'b0;
		if (st_q == hst_pkg::ST_DT_VALUE) begin
			load    = load_ok;
			nxt_hdr = hdr({hst_pkg::TYPE_VAL, dv_cmp_q, dv_wr_q}, dv_size_q);
			nxt_pay = (dv_size_q == hst_pkg::SS_1B) ? {24'h00_0000, dv_data_q[7:0]}
				: (dv_size_q == hst_pkg::SS_2B) ? {16'h0000, dv_data_q[15:0]} : dv_data_q;
		end else if (DT_VALID) begin
			DT_READY  = load_ok;
			dt_take   = load_ok;
			load      = load_ok && |func_sel[2:0];
			go_second = func_sel[hst_pkg::FUNC_CAP_BIT]
				&& (func_sel[hst_pkg::FUNC_PC_BIT] || func_sel[hst_pkg::FUNC_OFS_BIT]);
			if (func_sel[hst_pkg::FUNC_OFS_BIT]) begin
				nxt_hdr = hdr({hst_pkg::TYPE_PC, DT_CMP, 1'b1}, hst_pkg::SS_2B);
				nxt_pay = {16'h0000, DT_OFFSET};
			end else if (func_sel[hst_pkg::FUNC_PC_BIT]) begin
				nxt_hdr = hdr({hst_pkg::TYPE_PC, DT_CMP, 1'b0}, hst_pkg::SS_4B);
				nxt_pay = DT_PC;
			end else begin
				nxt_hdr = hdr({hst_pkg::TYPE_VAL, DT_CMP, DT_WRITE}, dt_ss);
				nxt_pay = (dt_ss == hst_pkg::SS_1B) ? {24'h00_0000, DT_DATA[7:0]}
					: (dt_ss == hst_pkg::SS_2B) ? {16'h0000, DT_DATA[15:0]} : DT_DATA;
			end
		end else if (EXC_VALID) begin
			EXC_READY = load_ok;
			exc_take  = load_ok && EXC_ACTION != hst_pkg::ACT_NONE;
			load      = exc_take;
			nxt_hdr   = hdr(hst_pkg::DISC_EXC, hst_pkg::SS_2B);
			nxt_pay   = {16'h0000, 2'b00, EXC_ACTION, 3'b000, EXC_INDEX[8], EXC_INDEX[7:0]};
		end else if (samp_pend_q && pc_en) begin
			smp_take = load_ok;
			load     = load_ok;
			if (samp_sleep_q) begin
				nxt_hdr = hdr(hst_pkg::DISC_SMP, hst_pkg::SS_1B);
				nxt_pay = 32'h0000_0000;
			end else begin
				nxt_hdr = hdr(hst_pkg::DISC_SMP, hst_pkg::SS_4B);
				nxt_pay = {samp_pc_q[31:1], 1'b0};
			end
		end
	end

	// ----------------------------------------
	// Pending sample and pair sequencing
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			samp_pend_q  <= 1'b0;
			samp_sleep_q <= 1'b0;
			samp_pc_q    <= 32'h0000_0000;
		end else if (expire) begin
			samp_pend_q  <= 1'b1;
			samp_sleep_q <= CORE_SLEEPING;
			samp_pc_q    <= CORE_PC;
		end else if (smp_take || !pc_en) begin
			samp_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			st_q      <= hst_pkg::ST_IDLE;
			dv_cmp_q  <= 2'h0;
			dv_size_q <= hst_pkg::SS_1B;
			dv_wr_q   <= 1'b0;
			dv_data_q <= 32'h0000_0000;
		end else begin
			case (st_q)
				hst_pkg::ST_IDLE: begin
					if (dt_take && go_second) begin
						st_q      <= hst_pkg::ST_DT_VALUE;
						dv_cmp_q  <= DT_CMP;
						dv_size_q <= dt_ss;
						dv_wr_q   <= DT_WRITE;
						dv_data_q <= DT_DATA;
					end
				end
				hst_pkg::ST_DT_VALUE: begin
					if (load)
						st_q <= hst_pkg::ST_IDLE;
				end
				default: st_q <= hst_pkg::ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Packet hand-off
	// ----------------------------------------
	always_ff @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			pkt_valid_q <= 1'b0;
			pkt_hdr_q   <= 8'h00;
			pkt_pay_q   <= 32'h0000_0000;
		end else if (load) begin
			pkt_valid_q <= 1'b1;
			pkt_hdr_q   <= nxt_hdr;
			pkt_pay_q   <= nxt_pay;
		end else if (PKT_READY) begin
			pkt_valid_q <= 1'b0;
		end
	end

	assign PKT_VALID   = pkt_valid_q;
	assign PKT_HEADER  = pkt_hdr_q;
	assign PKT_PAYLOAD = pkt_pay_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!NRST);

	sequence s_pair_start;
		dt_take && go_second;
	endsequence
	sequence s_first_out;
		pkt_valid_q && pkt_hdr_q[7:6] == hst_pkg::TYPE_PC && st_q == hst_pkg::ST_DT_VALUE;
	endsequence

	a_exc_header_fmt: assert property (
		exc_take |=> pkt_valid_q && pkt_hdr_q == 8'h0E)
		else $error("exception header wrong");
	a_exc_index_map: assert property (
		exc_take |=> pkt_pay_q[7:0] == $past(EXC_INDEX[7:0]) && pkt_pay_q[8] == $past(EXC_INDEX[8]))
		else $error("exception index misplaced");
	a_exc_action_code: assert property (
		exc_take |=> pkt_pay_q[13:12] == $past(EXC_ACTION) && pkt_pay_q[13:12] != 2'b00)
		else $error("exception action wrong");
	a_exc_resv_zero: assert property (
		pkt_valid_q && pkt_hdr_q[7:3] == hst_pkg::DISC_EXC |-> pkt_pay_q[31:14] == '0 && pkt_pay_q[11:9] == '0)
		else $error("reserved exception bits set");
	a_smp_on_expiry: assert property (
		expire |=> samp_pend_q && samp_pc_q == $past(CORE_PC))
		else $error("sample not captured at expiry");
	a_smp_enable_gate: assert property (
		load && nxt_hdr[7:3] == hst_pkg::DISC_SMP |-> pc_en)
		else $error("sample sent while disabled");
	a_smp_full_fmt: assert property (
		smp_take && !samp_sleep_q |=> pkt_hdr_q == 8'h17 && pkt_pay_q[0] == 1'b0)
		else $error("full sample format wrong");
	a_smp_sleep_fmt: assert property (
		smp_take && samp_sleep_q |=> pkt_hdr_q == 8'h15 && pkt_pay_q == 32'h0000_0000)
		else $error("sleep sample format wrong");
	a_dt_cmp_field: assert property (
		dt_take && load |=> pkt_hdr_q[5:4] == $past(DT_CMP) && pkt_hdr_q[2] == 1'b1)
		else $error("comparator field wrong");
	a_dt_pair_order: assert property (
		s_pair_start |=> s_first_out)
		else $error("pair first packet wrong");
	a_dt_pair_second: assert property (
		st_q == hst_pkg::ST_DT_VALUE && load |=> pkt_hdr_q[7:6] == hst_pkg::TYPE_VAL && st_q == hst_pkg::ST_IDLE)
		else $error("pair second packet wrong");
	a_pkt_hold: assert property (
		pkt_valid_q && !PKT_READY |=> pkt_valid_q && $stable(pkt_hdr_q) && $stable(pkt_pay_q))
		else $error("packet dropped before taken");
endmodule // hst_packetizer

// File: test/hst_itu_model.sv
// Instrumentation trace unit stand-in that takes and logs packets
`timescale 1ns/1ps
module hst_itu_model (
	input  wire logic        CORE_CLK,
	input  wire logic        NRST,
	input  wire logic        SLOW,
	input  wire logic        PKT_VALID,
	output logic             PKT_READY,
	input  wire logic [7:0]  PKT_HEADER,
	input  wire logic [31:0] PKT_PAYLOAD
);
	logic [7:0]  log_hdr[$];
	logic [31:0] log_pay[$];
	int          log_t[$];
	int          cyc_q;

	// ----------------------------------------
	// Acceptance, slow mode takes one in four
	// ----------------------------------------
	assign PKT_READY = !SLOW || (cyc_q[1:0] == 2'h3);

	always @(posedge CORE_CLK or negedge NRST) begin
		if (!NRST) begin
			cyc_q <= 0;
		end else begin
			cyc_q <= cyc_q + 1;
			if (PKT_VALID && PKT_READY) begin
				log_hdr.push_back(PKT_HEADER);
				log_pay.push_back(PKT_PAYLOAD);
				log_t.push_back(cyc_q);
			end
		end
	end
endmodule // hst_itu_model

// File: test/tb.sv
// Self-checking bench for the hardware-source trace packetizer
`timescale 1ns/1ps
module tb;
	logic        CORE_CLK = 1'b0, NRST = 1'b0, AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
	logic        ARVALID = 1'b0, RREADY = 1'b0, EXC_VALID = 1'b0, DT_VALID = 1'b0, DT_WRITE = 1'b0;
	logic        CORE_SLEEPING = 1'b0, SLOW = 1'b0;
	logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, EXC_READY, DT_READY, PKT_VALID, PKT_READY;
	logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00, PKT_HEADER;
	logic [31:0] WDATA = 32'h0, CORE_PC = 32'h0000_1235, DT_PC = 32'h0800_1A2C, DT_DATA = 32'hA1B2_C3D4;
	logic [31:0] RDATA, PKT_PAYLOAD;
	logic [3:0]  WSTRB = 4'hF;
	logic [1:0]  EXC_ACTION = 2'h0, DT_CMP = 2'h0, DT_SIZE = 2'h0, BRESP, RRESP;
	logic [8:0]  EXC_INDEX = 9'h000;
	logic [15:0] DT_OFFSET = 16'h5A3C;
	int          err_total = 0, checks = 0, last_t;

	hst_packetizer #(.RLD_W(4)) i_dut (
		.CORE_CLK, .NRST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
		.BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .EXC_VALID, .EXC_READY,
		.EXC_ACTION, .EXC_INDEX, .CORE_PC, .CORE_SLEEPING, .DT_VALID, .DT_READY, .DT_CMP, .DT_PC,
		.DT_OFFSET, .DT_DATA, .DT_SIZE, .DT_WRITE, .PKT_VALID, .PKT_READY, .PKT_HEADER, .PKT_PAYLOAD
	);
	hst_itu_model i_itu (.CORE_CLK, .NRST, .SLOW, .PKT_VALID, .PKT_READY, .PKT_HEADER, .PKT_PAYLOAD);

	always #5 CORE_CLK = ~CORE_CLK;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge CORE_CLK);
		AWADDR  <= a;
		AWVALID <= 1'b1;
		WDATA   <= d;
		WVALID  <= 1'b1;
		BREADY  <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			if (AWVALID && AWREADY) AWVALID <= 1'b0;
			if (WVALID && WREADY) WVALID <= 1'b0;
		end while (BVALID !== 1'b1);
		BREADY <= 1'b0;
		check("bresp", BRESP, er);
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge CORE_CLK);
		ARADDR  <= a;
		ARVALID <= 1'b1;
		RREADY  <= 1'b1;
		do begin
			@(posedge CORE_CLK);
			if (ARVALID && ARREADY) ARVALID <= 1'b0;
		end while (RVALID !== 1'b1);
		RREADY <= 1'b0;
		check("rdata", RDATA, ed);
		check("rresp", RRESP, er);
	endtask

	task automatic exc(input logic [1:0] act, input logic [8:0] idx);
		@(posedge CORE_CLK);
		EXC_VALID  <= 1'b1;
		EXC_ACTION <= act;
		EXC_INDEX  <= idx;
		do @(posedge CORE_CLK); while (EXC_READY !== 1'b1);
		EXC_VALID <= 1'b0;
	endtask

	task automatic dt(input logic [1:0] c, input logic wr, input logic [1:0] sz);
		@(posedge CORE_CLK);
		DT_VALID <= 1'b1;
		DT_CMP   <= c;
		DT_WRITE <= wr;
		DT_SIZE  <= sz;
		do @(posedge CORE_CLK); while (DT_READY !== 1'b1);
		DT_VALID <= 1'b0;
	endtask

	// Next logged packet against header and payload
	task automatic pkt(input logic [7:0] h, input logic [31:0] p);
		int n;
		n = 0;
		while (i_itu.log_hdr.size() == 0 && n < 3000) begin
			@(posedge CORE_CLK);
			n++;
		end
		if (n == 3000) begin
			check("packet wait", 32'h0, 32'h1);
		end else begin
			last_t = i_itu.log_t.pop_front();
			check("header", i_itu.log_hdr.pop_front(), h);
			check("payload", i_itu.log_pay.pop_front(), p);
		end
	endtask

	task automatic quiet(input int n);
		repeat (n) @(posedge CORE_CLK);
		check("extra packets", i_itu.log_hdr.size(), 0);
	endtask

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		int t0;
		repeat (3) @(posedge CORE_CLK);
		NRST <= 1'b1;
		axi_rd(hst_pkg::ADDR_CTRL, 32'h0, hst_pkg::RESP_OKAY);
		axi_rd(hst_pkg::ADDR_FUNC, 32'h0, hst_pkg::RESP_OKAY);
		axi_rd(hst_pkg::ADDR_STATUS, 32'h0, hst_pkg::RESP_OKAY);
		axi_rd(8'h10, 32'h0, hst_pkg::RESP_SLVERR);
		axi_wr(hst_pkg::ADDR_STATUS, 32'hFFFF_FFFF, hst_pkg::RESP_SLVERR);
		$display("test registers done");
		// Every action code into a stalling sink
		SLOW <= 1'b1;
		for (int a = 0; a < 4; a++) exc(a[1:0], 9'h1A5 ^ 9'(a));
		for (int a = 1; a < 4; a++) pkt(8'h0E, {16'h0, 2'b00, a[1:0], 3'b000, 1'b1, 8'hA5 ^ 8'(a)});
		quiet(20);
		$display("test exceptions done");
		// Comparators: value, PC and value, offset and value, PC alone
		axi_wr(hst_pkg::ADDR_FUNC, 32'h2531, hst_pkg::RESP_OKAY);
		axi_rd(hst_pkg::ADDR_FUNC, 32'h2531, hst_pkg::RESP_OKAY);
		for (int c = 0; c < 4; c++) dt(c[1:0], c[0], c[1:0]);
		pkt(8'h85, {24'h0, DT_DATA[7:0]});
		pkt(8'h57, DT_PC);
		pkt(8'h9E, {16'h0, DT_DATA[15:0]});
		pkt(8'h6E, {16'h0, DT_OFFSET});
		pkt(8'hA7, DT_DATA);
		pkt(8'h77, DT_PC);
		quiet(20);
		axi_wr(hst_pkg::ADDR_FUNC, 32'h0, hst_pkg::RESP_OKAY);
		dt(2'h1, 1'b0, 2'h2);
		quiet(20);
		$display("test data trace done");
		// Sampling at reload 1 on the fine tap, then reload 0 on the coarse tap
		SLOW <= 1'b0;
		axi_wr(hst_pkg::ADDR_CTRL, 32'h11, hst_pkg::RESP_OKAY);
		pkt(8'h17, 32'h0000_1234);
		t0 = last_t;
		pkt(8'h17, 32'h0000_1234);
		check("fine period", last_t - t0, (1 + 1) * (2 ** (hst_pkg::TAP_LO + 1)));
		CORE_SLEEPING <= 1'b1;
		pkt(8'h15, 32'h0);
		axi_wr(hst_pkg::ADDR_CTRL, 32'h0, hst_pkg::RESP_OKAY);
		CORE_SLEEPING <= 1'b0;
		quiet(400);
		axi_wr(hst_pkg::ADDR_CTRL, 32'h3, hst_pkg::RESP_OKAY);
		pkt(8'h17, 32'h0000_1234);
		t0 = last_t;
		pkt(8'h17, 32'h0000_1234);
		check("coarse period", last_t - t0, (0 + 1) * (2 ** (hst_pkg::TAP_HI + 1)));
		axi_wr(hst_pkg::ADDR_CTRL, 32'h0, hst_pkg::RESP_OKAY);
		quiet(1200);
		$display("test sampling done");
		test_done();
	end

	// Hang guard, about eight times the expected run
	initial begin
		#500000;
		err_total++;
		test_done();
	end
endmodule // tb
